// file: common/sound_gen_pkg.sv
// constants shared by the three-channel sound generator
package sound_gen_pkg;
  localparam logic [3:0] reg_a_fine     = 4'h0;
  localparam logic [3:0] reg_a_coarse   = 4'h1;
  localparam logic [3:0] reg_b_fine     = 4'h2;
  localparam logic [3:0] reg_b_coarse   = 4'h3;
  localparam logic [3:0] reg_c_fine     = 4'h4;
  localparam logic [3:0] reg_c_coarse   = 4'h5;
  localparam logic [3:0] reg_noise      = 4'h6;
  localparam logic [3:0] reg_mixer      = 4'h7;
  localparam logic [3:0] reg_a_level    = 4'h8;
  localparam logic [3:0] reg_b_level    = 4'h9;
  localparam logic [3:0] reg_c_level    = 4'ha;
  localparam logic [3:0] reg_env_low    = 4'hb;
  localparam logic [3:0] reg_env_high   = 4'hc;
  localparam logic [3:0] reg_env_shape  = 4'hd;
  localparam logic [3:0] reg_io_port    = 4'he;
  localparam logic [3:0] reg_spare      = 4'hf;
  localparam int         num_regs       = 16;
  localparam logic [7:0] reg_reset      = 8'h00;
  localparam logic [7:0] mixer_reset    = 8'hff;
  localparam logic [3:0] prescale_last  = 4'hf;
  localparam int         coarse_lsb     = 8;
  localparam int         noise_tone_ofs = 3;
  localparam int         io_dir_bit     = 6;
  localparam int         env_mode_bit   = 4;
  localparam logic [16:0] lfsr_seed     = 17'h00001;
  localparam logic [11:0] period_one    = 12'h001;
  localparam logic [4:0]  noise_one     = 5'h01;
endpackage

// file: hdl/period_divider.sv
// programmable divider toggling a square wave once per period
`timescale 1ns/1ps
`default_nettype none
module period_divider #(
  parameter int w = 12
) (
  input  wire logic         clk,     // system clock
  input  wire logic         rst,     // synchronous reset
  input  wire logic         tick,    // prescaled step
  input  wire logic [w-1:0] period,  // division value
  output var  logic         wave     // square wave out
);
  typedef struct packed {
    logic [w-1:0] cnt;
    logic         wave;
  } div_state_type;
  div_state_type s_q;
  div_state_type s_d;
  logic [w-1:0] eff;
  always_comb
  begin
    s_d = s_q;
    eff = (period == '0) ? w'(1) : period;
    if (tick)
    begin
      if (s_q.cnt + w'(1) >= eff)
      begin
        s_d.cnt  = '0;
        s_d.wave = ~s_q.wave;
      end
      else
      begin
        s_d.cnt = s_q.cnt + w'(1);
      end
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign wave = s_q.wave;
endmodule // period_divider
`default_nettype wire

// file: hdl/sound_generator.sv
// three-channel sound generator with index and data host ports
// How it works
// - host uses index port and data port
// - sixteen eight-bit registers, indices 0-15
// - clock divided by sixteen then period
// - period is 256 times coarse bits 3-0 plus fine
// - channel periods from register pairs 1/0,3/2,5/4
// - period one divides by one, max 4095
// - io port independent of sound logic
// - sixteen-level output per channel
// - level fixed or from envelope
// - mixer combines tone and noise
// - envelope level drives channels with level bit 4 set
// - pseudo-random noise square wave
// - noise period from register 6 bits 4-0
// - register 7 gates noise, tone, io direction
// - bit 4 selects envelope, zero silences
`timescale 1ns/1ps
`default_nettype none
module sound_generator (
  input  wire logic       clk,         // 10 MHz clock
  input  wire logic       rst,         // synchronous reset
  input  wire logic       ce,          // clock enable, freezes all
  input  wire logic       index_wr,    // write strobe, index port
  input  wire logic       data_wr,     // write strobe, data port
  input  wire logic       data_rd,     // read strobe, data port
  input  wire logic [7:0] wr_data,     // host write data
  output var  logic [7:0] rd_data,     // host read data
  input  wire logic [7:0] io_in,       // general_io_port_a pins in
  output var  logic [7:0] io_out,      // general_io_port_a pins out
  output var  logic       io_oe,       // io port output enable
  output var  logic [3:0] level_a,     // channel a level
  output var  logic [3:0] level_b,     // channel b level
  output var  logic [3:0] level_c      // channel c level
);
  typedef struct packed {
    logic [3:0]       index;
    logic [15:0][7:0] regs;
    logic [3:0]       pre;
    logic [4:0]       ncnt;
    logic [16:0]      lfsr;
    logic [15:0]      ecnt;
    logic [4:0]       estep;
    logic [7:0]       rd;
    logic [7:0]       io_out;
    logic             io_oe;
    logic [2:0][3:0]  lvl;
  } top_state_type;
  top_state_type s_q;
  top_state_type s_d;
  logic        tick;
  logic [2:0]  tone_wave;
  logic [11:0] tone_per [3];
  logic [3:0]  env_level;
  logic [4:0]  np;
  logic [15:0] ep;
  logic [7:0]  mix_reg;

  assign tick = ce && (s_q.pre == sound_gen_pkg::prescale_last);
  assign mix_reg = s_q.regs[sound_gen_pkg::reg_mixer];

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++)
    begin : g_tone
      assign tone_per[ch] = {s_q.regs[2*ch+1][3:0], s_q.regs[2*ch]};
      period_divider #(.w(12)) u_div (
        .clk    (clk),
        .rst    (rst),
        .tick   (tick),
        .period (tone_per[ch]),
        .wave   (tone_wave[ch])
      );
    end
  endgenerate

  assign np = s_q.regs[sound_gen_pkg::reg_noise][4:0];
  assign ep = {s_q.regs[sound_gen_pkg::reg_env_high], s_q.regs[sound_gen_pkg::reg_env_low]};
  // simple falling envelope, shape left to the shape register owner
  assign env_level = s_q.estep[4] ? 4'h0 : ~s_q.estep[3:0];

  always_comb
  begin
    logic [3:0] amp;
    logic       tone_on;
    logic       noise_on;
    logic       mixed;
    logic [7:0] lr;
    amp      = 4'h0;
    tone_on  = 1'b0;
    noise_on = 1'b0;
    mixed    = 1'b0;
    lr       = 8'h00;
    s_d = s_q;
    if (ce)
    begin
      s_d.pre = s_q.pre + 4'h1;
      if (index_wr)
        s_d.index = wr_data[3:0];
      else if (data_wr)
        s_d.regs[s_q.index] = wr_data;
      if (data_rd)
      begin
        if (s_q.index == sound_gen_pkg::reg_io_port && !mix_reg[sound_gen_pkg::io_dir_bit])
          s_d.rd = io_in;
        else
          s_d.rd = s_q.regs[s_q.index];
      end
      if (index_wr == 1'b0 && data_wr && s_q.index == sound_gen_pkg::reg_env_shape)
      begin
        s_d.ecnt  = 16'h0000;
        s_d.estep = 5'h00;
      end
      else if (tick)
      begin
        if (s_q.ncnt + 5'h01 >= ((np == 5'h00) ? sound_gen_pkg::noise_one : np))
        begin
          s_d.ncnt = 5'h00;
          s_d.lfsr = {s_q.lfsr[15:0], s_q.lfsr[16] ^ s_q.lfsr[13]};
          if (s_d.lfsr == 17'h00000)
            s_d.lfsr = sound_gen_pkg::lfsr_seed;
        end
        else
          s_d.ncnt = s_q.ncnt + 5'h01;
        if (s_q.ecnt + 16'h0001 >= ((ep == 16'h0000) ? 16'h0001 : ep))
        begin
          s_d.ecnt = 16'h0000;
          if (!s_q.estep[4])
            s_d.estep = s_q.estep + 5'h01;
        end
        else
          s_d.ecnt = s_q.ecnt + 16'h0001;
      end
      s_d.io_oe  = mix_reg[sound_gen_pkg::io_dir_bit];
      s_d.io_out = s_q.regs[sound_gen_pkg::reg_io_port];
      for (int i = 0; i < 3; i++)
      begin
        lr = s_q.regs[int'(sound_gen_pkg::reg_a_level) + i];
        tone_on  = ~mix_reg[i];
        noise_on = ~mix_reg[i + sound_gen_pkg::noise_tone_ofs];
        mixed = (tone_wave[i] | ~tone_on) & (s_q.lfsr[0] | ~noise_on);
        amp = lr[sound_gen_pkg::env_mode_bit] ? env_level : lr[3:0];
        s_d.lvl[i] = mixed ? amp : 4'h0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.regs[sound_gen_pkg::reg_mixer] <= sound_gen_pkg::mixer_reset;
      s_q.lfsr <= sound_gen_pkg::lfsr_seed;
    end
    else
      s_q <= s_d;
  end

  assign rd_data = s_q.rd;
  assign io_out  = s_q.io_out;
  assign io_oe   = s_q.io_oe;
  assign level_a = s_q.lvl[0];
  assign level_b = s_q.lvl[1];
  assign level_c = s_q.lvl[2];
endmodule // sound_generator
`default_nettype wire

// file: bench/sound_generator_assertions.sv
// port checker for the sound generator
`timescale 1ns/1ps
`default_nettype none
module sound_generator_checker (
  input wire logic       clk,      // clock
  input wire logic       rst,      // reset
  input wire logic       ce,       // enable
  input wire logic       index_wr, // index strobe
  input wire logic       data_wr,  // write strobe
  input wire logic       data_rd,  // read strobe
  input wire logic [7:0] wr_data,  // write data
  input wire logic [7:0] rd_data,  // read data
  input wire logic [7:0] io_out,   // port out
  input wire logic       io_oe,    // port drive
  input wire logic [3:0] level_a,  // level a
  input wire logic [3:0] level_b,  // level b
  input wire logic [3:0] level_c   // level c
);
  logic [3:0] idx_q;
  logic [7:0] sp_q;
  logic       amp_q;
  wire        wr = ce && data_wr && !index_wr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // mirror of the latched index and the spare store
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      idx_q <= 4'h0;
      sp_q <= 8'h00;
      amp_q <= 1'b0;
    end
    else
    begin
      if (ce && index_wr) idx_q <= wr_data[3:0];
      if (wr && idx_q == 4'hf) sp_q <= wr_data;
      if (wr && idx_q >= 4'h8 && idx_q <= 4'ha) amp_q <= 1'b1;
    end
  end
  property p_rst; disable iff (1'b0) rst |=> rd_data == 8'h00 && io_out == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_frz; !ce |=> $stable({rd_data, io_out, io_oe, level_a, level_b, level_c}); endproperty
  a_frz: assert property (p_frz) else $error("moved while frozen");
  property p_rdh; !$stable(rd_data) |-> $past(ce && data_rd) || $past(rst); endproperty
  a_rdh: assert property (p_rdh) else $error("read data moved");
  property p_oe; wr && idx_q == 4'h7 ##1 ce |=> io_oe == $past(wr_data[6], 2); endproperty
  a_oe: assert property (p_oe) else $error("port direction");
  property p_out; wr && idx_q == 4'he ##1 ce |=> io_out == $past(wr_data, 2); endproperty
  a_out: assert property (p_out) else $error("port value");
  property p_one; !$stable(io_out) |-> $past(wr && idx_q == 4'he, 2) || $past(rst, 2)
    || $past(wr && idx_q == 4'he) || $past(rst); endproperty
  a_one: assert property (p_one) else $error("port disturbed");
  property p_sil; !amp_q |-> {level_a, level_b, level_c} == 12'h000; endproperty
  a_sil: assert property (p_sil) else $error("silent level");
  property p_sp; ce && data_rd && !data_wr && !index_wr && idx_q == 4'hf |=> rd_data == sp_q;
  endproperty
  a_sp: assert property (p_sp) else $error("store readback");
endmodule // sound_generator_checker
bind sound_generator sound_generator_checker chk_u (.clk, .rst, .ce, .index_wr, .data_wr,
  .data_rd, .wr_data, .rd_data, .io_out, .io_oe, .level_a, .level_b, .level_c);
`default_nettype wire

// file: bench/host_model.sv
// host side of the index and data ports
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk,      // clock
  output var  logic       index_wr, // index strobe
  output var  logic       data_wr,  // write strobe
  output var  logic       data_rd,  // read strobe
  output var  logic [7:0] wr_data,  // bus data
  input  wire logic [7:0] rd_data   // read data
);
  initial
  begin
    {index_wr, data_wr, data_rd} = 3'h0;
    wr_data = 8'h00;
  end
  // index write, then one data access
  task automatic acc(input logic [3:0] i, input logic [7:0] v, input bit w,
    output logic [7:0] r);
    @(posedge clk) #1;
    index_wr = 1'b1;
    wr_data = {4'h0, i};
    @(posedge clk) #1;
    index_wr = 1'b0;
    data_wr = w;
    data_rd = !w;
    wr_data = v;
    @(posedge clk) #1;
    r = rd_data;
    data_wr = 1'b0;
    data_rd = 1'b0;
    wr_data = ~v;
  endtask
endmodule // host_model
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench for the sound generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk, rst, ce, index_wr, data_wr, data_rd, io_oe;
  logic [7:0] wr_data, rd_data, io_out, r;
  logic [3:0] level_a, level_b, level_c;
  logic [7:0] fine [3] = '{8'h00, 8'h01, 8'h03};
  int         failures, checks_done, n;
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  sound_generator dut_u (.clk, .rst, .ce, .index_wr, .data_wr, .data_rd, .wr_data,
    .rd_data, .io_in(8'h5a), .io_out, .io_oe, .level_a, .level_b, .level_c);
  host_model host_u (.clk, .index_wr, .data_wr, .data_rd, .wr_data, .rd_data);
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic put(input logic [3:0] i, input logic [7:0] v);
    host_u.acc(i, v, 1'b1, r);
  endtask
  task automatic gap();
    logic [3:0] v;
    v = level_a;
    n = 0;
    while (level_a === v && n < 400)
    begin
      @(posedge clk) #1;
      n++;
    end
    if (n >= 400)
    begin
      failures++;
      $display("MISMATCH level_a_edge expected edge seen none");
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    failures = 0;
    checks_done = 0;
    rst = 1'b1;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 16; i++) put(i[3:0], 8'hc0 | i[7:0]);
    for (int i = 0; i < 16; i++)
    begin
      host_u.acc(i[3:0], 8'h00, 1'b0, r);
      chk("readback", 8'hc0 | i[7:0], r);
    end
    put(4'h7, 8'hbf);
    host_u.acc(4'he, 8'h00, 1'b0, r);
    chk("port_in", 8'h5a, r);
    chk("port_out", 8'hce, io_out);
    chk("port_dir", 8'h00, {7'h0, io_oe});
    put(4'h8, 8'h0b);
    #300;
    chk("fixed_level", 8'h0b, {4'h0, level_a});
    chk("level_b", 8'h09, {4'h0, level_b});
    chk("level_c", 8'h0a, {4'h0, level_c});
    put(4'h9, 8'h10);
    #300;
    chk("env_level", 8'h0f, {4'h0, level_b});
    put(4'h7, 8'hbe);
    put(4'h8, 8'h0f);
    put(4'h1, 8'hf0);
    for (int k = 0; k < 3; k++)
    begin
      put(4'h0, fine[k]);
      gap();
      gap();
      gap();
      chk("half_period", 8'h10 * (fine[k] == 8'h00 ? 8'h01 : fine[k]), n[7:0]);
    end
    ce = 1'b0;
    #500;
    ce = 1'b1;
    put(4'h8, 8'h00);
    #300;
    chk("silent", 8'h00, {4'h0, level_a});
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
